// ==== sbs_regbank.sv ====
// Secondary bus status flags and memory window base and limit registers
`timescale 1ns/1ps
`default_nettype none
`include "sbs_cfg.svh"

// What this block does
// R01 - Set target-abort-signalled flag, bit 11, when bridge target-aborts on secondary bus.
// R02 - Device-select timing, bits 10:9, reads fixed 01b: medium-speed decode.
// R03 - Set master parity flag, bit 8, only as master, parity enabled, PERR seen.
// R04 - Fast back-to-back bit 7 reads fixed 1b.
// R05 - Status bits 6 and 4:0 are reserved and read as zero.
// R06 - Bit 5 shows the 66-MHz enable pin level; bus clock at most 66 MHz.
// R07 - Event flags stay set until software writes one; writing zero keeps them.
// R08 - Window base field bits 15:4 is read/write, address bits 31:20.
// R09 - Base compare treats the low 20 address bits as zeros.
// R10 - Base bits 3:0 read zero; register resets to 0000h.
// R11 - Base is the lower bound for forwarding memory downstream.
// R12 - Limit field gives bits 31:20 of the upper bound; low bits all ones.
module sbs_regbank
  import sbs_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int GRAN_BITS = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sbs_cfg_req_t cfg_req,
  output logic [15:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_wack,
  input wire sbs_bus_evt_t bus_evt,
  input wire logic parity_response_enable,
  input wire logic high_freq_enable_pin,
  input wire sbs_mem_req_t mem_req,
  output logic fwd_valid,
  output logic fwd_hit,
  output logic signalled_target_abort_flag,
  output logic master_data_parity_flag,
  output logic [11:0] window_base_field,
  output logic [11:0] window_limit_field
);

  localparam int FIELD_W = ADDR_W - GRAN_BITS;

  // The register layout only carries a 12-bit window field
  if (FIELD_W != (`SBS_WIN_FIELD_HI - `SBS_WIN_FIELD_LO + 1)) begin : g_bad_width
    $error("sbs_regbank: ADDR_W - GRAN_BITS must equal the 12-bit window field");
  end

  // The memory request carries a full ADDR_W-bit byte address
  if (ADDR_W != $bits(sbs_mem_req_t) - 1) begin : g_bad_addr
    $error("sbs_regbank: ADDR_W must match the memory request address width");
  end

  // The write mask must cover the window field and nothing else
  if (`SBS_WIN_RW_MASK != 16'(((1 << FIELD_W) - 1) << `SBS_WIN_FIELD_LO)) begin : g_bad_mask
    $error("sbs_regbank: window write mask does not match the field");
  end

  // Reserved nibbles must come out of reset as zero, as software expects
  if ((`SBS_MEM_BASE_RST & ~`SBS_WIN_RW_MASK) != 16'h0000 ||
      (`SBS_MEM_LIMIT_RST & ~`SBS_WIN_RW_MASK) != 16'h0000) begin : g_bad_rst
    $error("sbs_regbank: window reset values must keep bits 3:0 clear");
  end

  // Registers are 16 bits wide, so offsets must be even and distinct
  if ((`SBS_OFF_SEC_STATUS & 8'h01) != 8'h00 || (`SBS_OFF_MEM_BASE & 8'h01) != 8'h00 ||
      (`SBS_OFF_MEM_LIMIT & 8'h01) != 8'h00) begin : g_odd_offset
    $error("sbs_regbank: register offsets must be 16-bit aligned");
  end
  if (`SBS_OFF_MEM_BASE == `SBS_OFF_SEC_STATUS || `SBS_OFF_MEM_LIMIT == `SBS_OFF_SEC_STATUS ||
      `SBS_OFF_MEM_LIMIT == `SBS_OFF_MEM_BASE) begin : g_same_offset
    $error("sbs_regbank: register offsets must differ");
  end

  // Each flag position must index a bit of the 16-bit write data
  if (`SBS_BIT_SIGNALLED_TARGET_ABORT_FLAG > 15 || `SBS_BIT_MDATA_PAR > 15) begin : g_bad_flag_pos
    $error("sbs_regbank: status flag position outside the register");
  end

  // Byte-lane merge of a 16-bit register write
  function automatic logic [15:0] merge16(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] be
  );
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (be[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : merge16

  // Write-one-to-clear decode for one status bit, honouring its lane
  function automatic logic w1c_hit(
    input logic [15:0] wdata,
    input logic [1:0] be,
    input int unsigned pos
  );
    logic lane;
    lane = (pos >= 8) ? be[1] : be[0];
    return lane & wdata[pos];
  endfunction : w1c_hit

  // Slot match for one 16-bit register on its byte offset
  function automatic logic slot_hit(
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    return addr == offset;
  endfunction : slot_hit

  // Address decode

  logic sel_status;
  logic sel_base;
  logic sel_limit;
  logic sel_any;
  logic wr_status;
  logic wr_base;
  logic wr_limit;

  // Only the three 16-bit registers answer; other offsets read zero
  assign sel_status = slot_hit(cfg_req.addr, `SBS_OFF_SEC_STATUS);
  assign sel_base = slot_hit(cfg_req.addr, `SBS_OFF_MEM_BASE);
  assign sel_limit = slot_hit(cfg_req.addr, `SBS_OFF_MEM_LIMIT);
  assign sel_any = sel_status | sel_base | sel_limit;
  assign wr_status = cfg_req.wr & sel_status;
  assign wr_base = cfg_req.wr & sel_base;
  assign wr_limit = cfg_req.wr & sel_limit;

  // Status event flags

  logic tabort_set;
  logic tabort_clr;
  logic mpar_set;
  logic mpar_clr;
  logic mpar_perr;

  // Target abort signalled by the bridge as secondary target
  assign tabort_set = bus_evt.tgt_abort_signalled; // R01

  // Master parity needs mastership, enabled response and a PERR event
  assign mpar_perr = bus_evt.perr_driven_on_read | bus_evt.perr_seen_on_write;
  assign mpar_set = bus_evt.bus_master & parity_response_enable & mpar_perr; // R03

  // Only a written one clears; a zero leaves the flag alone
  assign tabort_clr = wr_status & w1c_hit(cfg_req.wdata, cfg_req.be,
                                          `SBS_BIT_SIGNALLED_TARGET_ABORT_FLAG); // R07
  assign mpar_clr = wr_status & w1c_hit(cfg_req.wdata, cfg_req.be,
                                        `SBS_BIT_MDATA_PAR); // R07

  // One sticky flag per status event
  sbs_w1c_flag u_tabort_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set(tabort_set),
    .clr(tabort_clr),
    .flag_q(signalled_target_abort_flag)
  );

  sbs_w1c_flag u_mpar_flag (
    .clk(clk),
    .rst_n(rst_n),
    .set(mpar_set),
    .clr(mpar_clr),
    .flag_q(master_data_parity_flag)
  );

  // Memory window base and limit registers

  logic [15:0] base_q;
  logic [15:0] base_d;
  logic [15:0] limit_q;
  logic [15:0] limit_d;
  logic [15:0] base_wr_val;
  logic [15:0] limit_wr_val;

  // Byte-merged write values; only bits 15:4 take writes, the reserved nibble stays zero
  assign base_wr_val = merge16(base_q, cfg_req.wdata, cfg_req.be) & `SBS_WIN_RW_MASK; // R08 R10
  assign limit_wr_val = merge16(limit_q, cfg_req.wdata, cfg_req.be) & `SBS_WIN_RW_MASK; // R12

  // A register keeps its value unless its own offset is written
  assign base_d = wr_base ? base_wr_val : base_q; // R08
  assign limit_d = wr_limit ? limit_wr_val : limit_q;

  // Window registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_q <= `SBS_MEM_BASE_RST; // R10
      limit_q <= `SBS_MEM_LIMIT_RST;
    end else begin
      base_q <= base_d;
      limit_q <= limit_d;
    end
  end

  // Field views leave the block straight from the register bits
  assign window_base_field = base_q[`SBS_WIN_FIELD_HI:`SBS_WIN_FIELD_LO]; // R08
  assign window_limit_field = limit_q[`SBS_WIN_FIELD_HI:`SBS_WIN_FIELD_LO];

  // Read-back

  logic [15:0] status_rd;
  logic [15:0] rd_mux;
  logic [3:0] upper_status;
  logic [1:0] devsel_timing;
  logic fast_b2b_capable_bit;
  logic reserved_bit6;
  logic high_freq_capable_bit;
  logic [4:0] reserved_low;

  // Upper status bits belong to other logic and read zero here
  assign upper_status = 4'h0;

  // Fixed capability fields never depend on bus state
  assign devsel_timing = `SBS_DEVSEL_TIMING; // R02
  assign fast_b2b_capable_bit = `SBS_FAST_B2B_VAL; // R04

  // Reserved bits are tied low so software always reads zero
  assign reserved_bit6 = 1'b0; // R05
  assign reserved_low = 5'h00; // R05

  // The speed bit follows the pin with no latch, so a changed strap shows on the next read
  assign high_freq_capable_bit = high_freq_enable_pin; // R06

  // Status image from bit 15 down to bit 0
  assign status_rd = {upper_status, signalled_target_abort_flag, devsel_timing,
                      master_data_parity_flag, fast_b2b_capable_bit, reserved_bit6,
                      high_freq_capable_bit, reserved_low}; // R01 R03

  // Unmapped offsets return zero rather than an error
  assign rd_mux = sel_status ? status_rd :
                  sel_base ? base_q :
                  sel_limit ? limit_q :
                  16'h0000;

  logic [15:0] rdata_d;
  logic rvalid_d;
  logic wack_d;

  // Read data holds its value between reads
  assign rdata_d = cfg_req.rd ? rd_mux : cfg_rdata;
  assign rvalid_d = cfg_req.rd;
  assign wack_d = cfg_req.wr & sel_any;

  // Configuration answer registers, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_rdata <= 16'h0000;
      cfg_rvalid <= 1'b0;
      cfg_wack <= 1'b0;
    end else begin
      cfg_rdata <= rdata_d;
      cfg_rvalid <= rvalid_d;
      cfg_wack <= wack_d;
    end
  end

  // Downstream forwarding decision

  logic win_hit;
  logic win_above;
  logic win_below;

  sbs_win_cmp #(
    .ADDR_W(ADDR_W),
    .GRAN_BITS(GRAN_BITS)
  ) u_win_cmp (
    .base_field(window_base_field),
    .limit_field(window_limit_field),
    .addr(mem_req.addr),
    .above_base(win_above),
    .below_limit(win_below),
    .hit()
  );

  // Both bounds are inclusive; a limit below the base never hits
  assign win_hit = win_above & win_below; // R11 R12

  logic fwd_valid_d;
  logic fwd_hit_d;

  // Compare uses the window as it stands in the request cycle
  assign fwd_valid_d = mem_req.valid;
  assign fwd_hit_d = mem_req.valid & win_hit; // R11

  // Registered so the decision leaves the block from a flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fwd_valid <= 1'b0;
      fwd_hit <= 1'b0;
    end else begin
      fwd_valid <= fwd_valid_d;
      fwd_hit <= fwd_hit_d;
    end
  end

endmodule : sbs_regbank

`default_nettype wire

// ==== sbs_cfg.svh ====
// Offsets, field positions and reset values of the secondary status and memory window registers
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH

// Configuration space byte offsets
`define SBS_OFF_SEC_STATUS 8'h1e
`define SBS_OFF_MEM_BASE 8'h20
`define SBS_OFF_MEM_LIMIT 8'h22

// Secondary status field positions
`define SBS_BIT_SIGNALLED_TARGET_ABORT_FLAG 11
`define SBS_BIT_DEVSEL_HI 10
`define SBS_BIT_DEVSEL_LO 9
`define SBS_BIT_MDATA_PAR 8
`define SBS_BIT_FAST_B2B 7
`define SBS_BIT_RSVD6 6
`define SBS_BIT_HIGH_FREQ 5

// Fixed read-only values
`define SBS_DEVSEL_TIMING 2'h1
`define SBS_FAST_B2B_VAL 1'h1

// Memory window register layout
`define SBS_WIN_FIELD_HI 15
`define SBS_WIN_FIELD_LO 4
`define SBS_WIN_RW_MASK 16'hfff0
`define SBS_MEM_BASE_RST 16'h0000
`define SBS_MEM_LIMIT_RST 16'h0000
`define SBS_WIN_BASE_FILL 20'h00000
`define SBS_WIN_LIMIT_FILL 20'hfffff

`endif

// ==== sbs_pkg.sv ====
// Types shared by the secondary status and memory window register bank
package sbs_pkg;

  // One configuration space access, 16-bit register wide
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } sbs_cfg_req_t;

  // One upstream memory request to be checked against the window
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } sbs_mem_req_t;

  // Events seen on the secondary PCI interface
  typedef struct packed {
    logic tgt_abort_signalled;
    logic bus_master;
    logic perr_driven_on_read;
    logic perr_seen_on_write;
  } sbs_bus_evt_t;

endpackage : sbs_pkg

// ==== sbs_w1c_flag.sv ====
// Sticky event flag that software clears by writing one
`timescale 1ns/1ps
`default_nettype none

module sbs_w1c_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);

  logic flag_d;

  // A set in the same cycle as a clear wins, so no event is lost
  assign flag_d = set | (flag_q & ~clr); // R07

  // Flag storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : sbs_w1c_flag

`default_nettype wire

// ==== sbs_win_cmp.sv ====
// Address range compare for the downstream memory window
`timescale 1ns/1ps
`default_nettype none

module sbs_win_cmp #(
  parameter int ADDR_W = 32,
  parameter int GRAN_BITS = 20
) (
  input wire logic [ADDR_W-GRAN_BITS-1:0] base_field,
  input wire logic [ADDR_W-GRAN_BITS-1:0] limit_field,
  input wire logic [ADDR_W-1:0] addr,
  output logic above_base,
  output logic below_limit,
  output logic hit
);

  // Refuse a granularity that leaves no field bits
  if (GRAN_BITS < 1 || GRAN_BITS >= ADDR_W) begin : g_bad_gran
    $error("sbs_win_cmp: GRAN_BITS must lie between 1 and ADDR_W-1");
  end

  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] limit_addr;

  // Base low bits are zeros, limit low bits are ones
  assign base_addr = {base_field, {GRAN_BITS{1'b0}}}; // R09
  assign limit_addr = {limit_field, {GRAN_BITS{1'b1}}}; // R12

  // Inclusive bounds; a limit below the base closes the window
  assign above_base = (addr >= base_addr); // R11
  assign below_limit = (addr <= limit_addr); // R12
  assign hit = above_base & below_limit;

endmodule : sbs_win_cmp

`default_nettype wire

// ==== sbs_regbank_asserts.sv ====
// Property checker for the secondary status and memory window bank
`timescale 1ns/1ps
`default_nettype none
module sbs_regbank_asserts
  import sbs_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int GRAN_BITS = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sbs_cfg_req_t cfg_req,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire logic cfg_wack,
  input wire sbs_bus_evt_t bus_evt,
  input wire logic parity_response_enable,
  input wire logic high_freq_enable_pin,
  input wire sbs_mem_req_t mem_req,
  input wire logic fwd_valid,
  input wire logic fwd_hit,
  input wire logic signalled_target_abort_flag,
  input wire logic master_data_parity_flag,
  input wire logic [11:0] window_base_field,
  input wire logic [11:0] window_limit_field
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Request decodes; names keep the properties short
  wire logic [7:0] a = cfg_req.addr;
  wire logic rd_st = cfg_req.rd && a == 8'h1e;
  wire logic clr_ta = cfg_req.wr && a == 8'h1e && cfg_req.be[1] && cfg_req.wdata[11];
  wire logic par_ok = bus_evt.bus_master && parity_response_enable
    && (bus_evt.perr_driven_on_read || bus_evt.perr_seen_on_write);
  wire logic unmapped = a != 8'h1e && a != 8'h20 && a != 8'h22;
  wire logic [11:0] wfield = cfg_req.wdata[15:4];
  wire logic [11:0] page = mem_req.addr[31:20];
  wire logic hit_now = page >= window_base_field && page <= window_limit_field;

  a_abort_sets: assert property (bus_evt.tgt_abort_signalled |=> signalled_target_abort_flag)
    else $error("abort flag not set after event");
  a_parity_gate: assert property ($rose(master_data_parity_flag) |-> $past(par_ok))
    else $error("parity flag set without cause");
  a_flag_sticky: assert property (signalled_target_abort_flag && !clr_ta |=>
    signalled_target_abort_flag) else $error("abort flag dropped");
  a_status_fixed: assert property (rd_st |=> cfg_rvalid && cfg_rdata[10:9] == 2'h1
    && cfg_rdata[7:6] == 2'h2 && cfg_rdata[4:0] == 5'h00) else $error("status fixed bits");
  a_pin_shown: assert property (rd_st |=> cfg_rdata[5] == $past(high_freq_enable_pin))
    else $error("status bit 5 not pin level");
  a_base_rsvd: assert property (cfg_req.rd && a == 8'h20 |=>
    cfg_rdata == {window_base_field, 4'h0}) else $error("base read value");
  a_base_write: assert property (cfg_req.wr && a == 8'h20 && cfg_req.be == 2'h3 |=>
    cfg_wack && window_base_field == $past(wfield)) else $error("base write");
  a_hit_bounds: assert property (mem_req.valid |=> fwd_valid && fwd_hit == $past(hit_now))
    else $error("window decision");
  a_fwd_quiet: assert property (!mem_req.valid |=> !fwd_valid && !fwd_hit)
    else $error("forward outputs without request");
  a_no_wack: assert property (cfg_req.wr && unmapped |=> !cfg_wack)
    else $error("unmapped write acknowledged");
  // Main scenarios seen
  c_abort_clear: cover property (signalled_target_abort_flag ##1 !signalled_target_abort_flag);
  c_hit: cover property (fwd_valid && fwd_hit);
  c_miss: cover property (fwd_valid && !fwd_hit);
endmodule : sbs_regbank_asserts

bind sbs_regbank sbs_regbank_asserts #(.ADDR_W(ADDR_W), .GRAN_BITS(GRAN_BITS)) u_chk (
  .clk, .rst_n, .cfg_req, .cfg_rdata, .cfg_rvalid, .cfg_wack, .bus_evt,
  .parity_response_enable, .high_freq_enable_pin, .mem_req, .fwd_valid, .fwd_hit,
  .signalled_target_abort_flag, .master_data_parity_flag, .window_base_field,
  .window_limit_field);
`default_nettype wire

// ==== sbs_bus_agent.sv ====
// Secondary bus agent that reports one event per command
`timescale 1ns/1ps
`default_nettype none
module sbs_bus_agent
  import sbs_pkg::*;
(
  input wire logic go,
  input wire logic [3:0] kind,
  output wire sbs_bus_evt_t bus_evt
);
  // Event lasts as long as go, one cycle per termination; idle is all zero
  assign bus_evt = go ? sbs_bus_evt_t'(kind) : '0;
endmodule : sbs_bus_agent
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the secondary status and memory window bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sbs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pre = 1'b0;
  logic pin = 1'b0;
  logic go = 1'b0;
  logic [3:0] kind = 4'h0;
  sbs_cfg_req_t req = '0;
  sbs_mem_req_t mreq = '0;
  wire sbs_bus_evt_t evt;
  logic [15:0] rdata;
  logic rvalid, wack, fv, fh, ta, dp;
  logic [11:0] bf, lf;
  int mismatches = 0;
  int check_count = 0;
  int unsigned seed = 34;
  int m_ta = 0, m_dp = 0;
  int m_win[2] = '{0, 0};

  always #2 clk = ~clk;

  sbs_bus_agent agent (.go(go), .kind(kind), .bus_evt(evt));
  sbs_regbank dut (.clk(clk), .rst_n(rst_n), .cfg_req(req), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .cfg_wack(wack), .bus_evt(evt), .parity_response_enable(pre),
    .high_freq_enable_pin(pin), .mem_req(mreq), .fwd_valid(fv), .fwd_hit(fh),
    .signalled_target_abort_flag(ta), .master_data_parity_flag(dp),
    .window_base_field(bf), .window_limit_field(lf));

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // Writes hold the request one cycle; wack is looked at in its only cycle
  task automatic cwr(logic [7:0] a, logic [1:0] be, logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, be, d};
    @(posedge clk);
    req <= '0;
    #1 chk("wack", wack, 32'(a == 8'h1e || a == 8'h20 || a == 8'h22));
  endtask : cwr

  task automatic crd(logic [7:0] a, logic [15:0] exp);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 2'h3, 16'h0000};
    @(posedge clk);
    req <= '0;
    #1 chk("rvalid", rvalid, 1);
    chk("rdata", rdata, exp);
  endtask : crd

  task automatic mem(logic [31:0] a);
    @(posedge clk);
    mreq <= '{1'b1, a};
    @(posedge clk);
    mreq <= '0;
    #1 chk("fwd_valid", fv, 1);
    chk("fwd_hit", fh, 32'(a[31:20] >= m_win[0] && a[31:20] <= m_win[1]));
  endtask : mem

  // Status image from the model flags and the pin level
  function automatic logic [15:0] st();
    return 16'h0280 | (16'(pin) << 5) | (16'(m_ta) << 11) | (16'(m_dp) << 8);
  endfunction : st

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Sequence: reset values, random byte writes, events, window decisions
  initial begin
    logic [15:0] d;
    logic [1:0] be;
    logic [7:0] k;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    pin <= 1'b1;
    @(posedge clk);
    crd(8'h1e, st());
    crd(8'h20, 16'h0000);
    crd(8'h22, 16'h0000);
    cwr(8'h24, 2'h3, 16'hffff);
    crd(8'h24, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      d = 16'(xs());
      be = 2'(xs());
      if (be[0]) m_win[i % 2][3:0] = d[7:4];
      if (be[1]) m_win[i % 2][11:4] = d[15:8];
      cwr(i % 2 ? 8'h22 : 8'h20, be, d);
      crd(i % 2 ? 8'h22 : 8'h20, 16'(m_win[i % 2] << 4));
      mem(xs());
    end
    chk("limit", lf, m_win[1]);
    for (int i = 0; i < 32; i++) begin
      k = 8'(i);
      @(posedge clk);
      pre <= k[4];
      pin <= 1'(xs());
      go <= 1'b1;
      kind <= k[3:0];
      @(posedge clk);
      go <= 1'b0;
      m_ta |= k[3];
      m_dp |= k[2] & k[4] & (k[1] | k[0]);
      #1 chk("abort", ta, m_ta);
      chk("parity", dp, m_dp);
      cwr(8'h1e, 2'h3, 16'h0000);
      crd(8'h1e, st());
      if (k[2:0] == 3'h7) begin
        cwr(8'h1e, 2'h3, 16'hffff);
        m_ta = 0;
        m_dp = 0;
        crd(8'h1e, st());
      end
    end
    cwr(8'h20, 2'h3, 16'h1230);
    cwr(8'h22, 2'h3, 16'h1250);
    m_win = '{12'h123, 12'h125};
    chk("base", bf, 12'h123);
    foreach (m_win[j]) begin
      mem({m_win[j][11:0], 20'h00000} - 32'(j));
      mem({m_win[j][11:0], 20'hfffff} + 32'(j));
    end
    mem(32'h122fffff);
    // Mid-run reset with a flag set and a written window
    @(posedge clk);
    go <= 1'b1;
    kind <= 4'h8;
    @(posedge clk);
    go <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    m_win = '{0, 0};
    #1 chk("abort_rst", ta, 0);
    crd(8'h20, 16'h0000);
    crd(8'h22, 16'h0000);
    chk("base_rst", bf, 0);
    mem(32'h000fffff);
    crd(8'h1e, st());
    wrap_up();
  end

  // Run is a few hundred cycles; this bound cuts a hang
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
